// [dv/rrs_host.sv]
`default_nettype none
module rrs_host (
	input wire logic clock,
	input wire logic sdo,
	output var logic cs_n = 1,
	output var logic sclk = 0,
	output var logic sdi = 0
);
	timeunit 1ns;
	timeprecision 1ns;
	task automatic xfer(logic [23:0] w, int n, output logic [7:0] r);
		cs_n = 0;
		for (int i = 23; i > 23 - n; i--) begin
			sdi = w[i];
			repeat (6) @(negedge clock);
			r = {r[6:0], sdo};
			sclk = 1;
			repeat (6) @(negedge clock);
			sclk = 0;
		end
		repeat (6) @(negedge clock);
		cs_n = 1;
		sdi = ~sdi;
		repeat (8) @(negedge clock);
	endtask
endmodule
`default_nettype wire

// [dv/rrs_spi_checker.sv]
`default_nettype none
module rrs_spi_checker (
	input wire logic clock,
	input wire logic rst,
	input wire logic shutdown,
	input wire logic chip_select_n,
	input wire logic sclk,
	input wire logic sdo_q,
	input wire logic sdo_oe,
	input wire logic wr_strobe_q
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	a_release_off: assert property (
		$rose(chip_select_n) |-> ##[1:6] !sdo_oe) else $error("oe late");
	a_idle_high: assert property (
		!sdo_oe |-> sdo_q) else $error("idle sdo low");
	a_shut_quiet: assert property (
		shutdown [*4] |-> !wr_strobe_q && !sdo_oe) else $error("shut act");
	a_strobe_pulse: assert property (
		wr_strobe_q |=> !wr_strobe_q) else $error("strobe long");
	a_write_select: assert property (
		wr_strobe_q |-> !chip_select_n) else $error("write unselected");
	a_oe_shutdown: assert property (
		sdo_oe |-> !$past(shutdown)) else $error("oe in shutdown");
	a_sdo_on_fall: assert property (
		sdo_oe && $changed(sdo_q) |-> !sclk) else $error("sdo moved high");
endmodule
bind rrs_spi_slave rrs_spi_checker chk_i (.clock(clock), .rst(rst),
	.sclk(sclk),
	.shutdown(shutdown), .chip_select_n(chip_select_n), .sdo_q(sdo_q),
	.sdo_oe(sdo_oe), .wr_strobe_q(wr_strobe_q));
`default_nettype wire

// [dv/rrs_spi_slave_tb.sv]
`default_nettype none
module rrs_spi_slave_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst = 1, sd = 0, oe, sq;
	wire logic cs, sc, si;
	logic [6:0] a;
	logic [7:0] r, m [128];
	int mismatches = 0, cmp_count = 0;
	always #50 clock = ~clock;
	rrs_host h (.clock(clock), .sdo(oe ? sq : 1'b1), .cs_n(cs), .sclk(sc),
		.sdi(si));
	rrs_spi_slave dut (.clock(clock), .rst(rst), .shutdown(sd),
		.chip_select_n(cs), .sclk(sc), .sdi(si), .sdo_q(sq), .sdo_oe(oe),
		.wr_addr_q(), .wr_data_q(), .wr_strobe_q());
	task automatic give_verdict;
		if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic rw(logic w, int n, logic [15:0] d);
		h.xfer({w, a, d}, n, r);
		if (w && n > 15) m[a] = d[15:8];
		if (w && n > 23) m[a + 7'h1] = d[7:0];
		if (!w) begin
			cmp_count++;
			if (r !== m[a + 7'(n / 8 - 2)]) begin
				mismatches++;
				$display("[FAIL] rd %h exp %h got %h", a,
					m[a + 7'(n / 8 - 2)], r);
			end
		end
	endtask
	initial begin
		void'($urandom(25545));
		foreach (m[i]) m[i] = 0;
		repeat (8) @(negedge clock);
		rst = 0;
		repeat (4) @(negedge clock);
		for (int k = 0; k < 12; k++) begin
			a = k == 11 ? 7'h7f : 7'($urandom);
			rw(1, k % 3 == 0 ? 12 : 8 * (k % 3) + 8, 16'($urandom));
			rw(0, 16 + 8 * (k % 2), 16'($urandom));
		end
		sd = 1;
		h.xfer({1'b1, a, 16'h5a5a}, 16, r);
		sd = 0;
		foreach (m[i]) m[i] = 0;
		repeat (8) @(negedge clock);
		rw(0, 16, 16'h0);
		give_verdict();
	end
	initial begin
		#2000000;
		mismatches++;
		give_verdict();
	end
endmodule
`default_nettype wire

// [hdl/rrs_consts.vh]
// Function
// [RULE1] Access is flag bit, seven address bits, eight data bits: sixteen total.
// [RULE2] Seven-bit address selects exactly one of 128 byte registers.
// [RULE3] Flag one means write, flag zero means read.
// [RULE4] Address or data byte captured after every eight serial clocks.
// [RULE5] Host keeps serial clock at or below 10 MHz.
// [RULE6] Serial input ignored during data phase of a read.
// [RULE7] Read data driven on the eight falling edges after the address.
// [RULE8] Output holds final data bit after read byte until select rises; code drives next register's bit 7 on the next falling edge.
// [RULE9] Select high: output not driven, reads as pulled high.
// [RULE10] Select held low: address increments, next register accessed each byte.
// [RULE11] Shutdown: no serial response, all register contents lost.
// [RULE12] MSB first, input sampled on rising edge, select low starts access.
// [RULE13] Select rising ends access, clears bit count, drops partial byte.
`ifndef RRS_CONSTS_VH
`define RRS_CONSTS_VH
`define RRS_ADDR_W 7
`define RRS_DATA_W 8
`define RRS_NUM_REGS 128
`define RRS_REG_RESET 8'h00
`define RRS_FLAG_WRITE 1'b1
`define RRS_BYTE_LAST 3'h7
`define RRS_SCLK_MAX_HZ 10000000
`define RRS_CLK_HZ 10000000
`endif

// [hdl/rrs_spi_slave.v]
`include "rrs_consts.vh"
`default_nettype none
module rrs_spi_slave #(
	parameter NUM_REGS = `RRS_NUM_REGS
) (
	input wire clock,
	input wire rst,
	input wire shutdown,
	input wire chip_select_n,
	input wire sclk,
	input wire sdi,
	output reg sdo_q,
	output wire sdo_oe,
	output reg [`RRS_ADDR_W-1:0] wr_addr_q,
	output reg [`RRS_DATA_W-1:0] wr_data_q,
	output reg wr_strobe_q
);
	wire sel_n_s;
	wire sclk_rise;
	wire sclk_fall;
	wire sdi_s;
	wire unused_a;
	wire unused_b;
	wire unused_c;
	wire unused_d;
	wire unused_e;
	wire unused_f;
	wire unused_g;
	wire unused_h;
	reg [`RRS_DATA_W-1:0] regs_q [0:NUM_REGS-1];
	reg [2:0] bit_cnt_q;
	reg [`RRS_DATA_W-1:0] shift_q;
	reg [`RRS_ADDR_W-1:0] addr_q;
	reg write_q;
	reg data_phase_q;
	reg [`RRS_DATA_W-1:0] tx_q;
	reg active_q;
	wire [`RRS_DATA_W-1:0] byte_in;
	wire dead;
	integer i;

	rrs_sync u_sel (
		.clock(clock),
		.rst(rst),
		.din(chip_select_n),
		.init(1'b1),
		.dout_q(sel_n_s),
		.rise(unused_a),
		.fall(unused_b)
	);
	rrs_sync u_sclk (
		.clock(clock),
		.rst(rst),
		.din(sclk),
		.init(1'b0),
		.dout_q(unused_c),
		.rise(sclk_rise),
		.fall(sclk_fall)
	);
	rrs_sync u_sdi (
		.clock(clock),
		.rst(rst),
		.din(sdi),
		.init(1'b0),
		.dout_q(sdi_s),
		.rise(unused_d),
		.fall(unused_e)
	);
	rrs_sync u_sdn (
		.clock(clock),
		.rst(rst),
		.din(shutdown),
		.init(1'b0),
		.dout_q(unused_f),
		.rise(unused_g),
		.fall(unused_h)
	);

	assign dead = rst || shutdown || unused_f; // RULE11
	assign byte_in = {shift_q[`RRS_DATA_W-2:0], sdi_s}; // RULE12
	// Registered with sdo_q, so the pin is released as it returns high
	assign sdo_oe = active_q; // RULE9

	always @(posedge clock) begin
		wr_strobe_q <= 1'b0;
		if (dead) begin
			for (i = 0; i < NUM_REGS; i = i + 1)
				regs_q[i] <= `RRS_REG_RESET; // RULE11
			bit_cnt_q <= 3'h0;
			shift_q <= 8'h00;
			addr_q <= 7'h00;
			write_q <= 1'b0;
			data_phase_q <= 1'b0;
			tx_q <= 8'h00;
			active_q <= 1'b0;
			sdo_q <= 1'b1;
			wr_addr_q <= 7'h00;
			wr_data_q <= 8'h00;
			wr_strobe_q <= 1'b0;
		end else if (sel_n_s) begin
			bit_cnt_q <= 3'h0; // RULE13
			data_phase_q <= 1'b0;
			active_q <= 1'b0;
			sdo_q <= 1'b1; // RULE9
		end else begin
			active_q <= 1'b1; // RULE12
			if (sclk_rise) begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
				shift_q <= byte_in; // RULE12
				if (bit_cnt_q == `RRS_BYTE_LAST) begin // RULE4
					if (!data_phase_q) begin // RULE1
						write_q <= byte_in[7] == `RRS_FLAG_WRITE; // RULE3
						addr_q <= byte_in[6:0]; // RULE2
						tx_q <= regs_q[byte_in[6:0]]; // RULE7
						data_phase_q <= 1'b1;
					end else begin
						if (write_q) begin // RULE6
							regs_q[addr_q] <= byte_in;
							wr_addr_q <= addr_q;
							wr_data_q <= byte_in;
							wr_strobe_q <= 1'b1;
						end
						addr_q <= addr_q + 7'h01; // RULE10
						tx_q <= regs_q[addr_q + 7'h01]; // RULE10
					end
				end
			end
			if (sclk_fall && data_phase_q && !write_q) begin
				sdo_q <= tx_q[`RRS_DATA_W-1]; // RULE7
				tx_q <= {tx_q[`RRS_DATA_W-2:0], tx_q[0]}; // RULE8
			end
		end
	end
endmodule
`default_nettype wire

// [hdl/rrs_sync.v]
`default_nettype none
module rrs_sync (
	input wire clock,
	input wire rst,
	input wire din,
	input wire init,
	output reg dout_q,
	output wire rise,
	output wire fall
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	// Change accepted only when second and third stages agree
	always @(posedge clock) begin
		if (rst) begin
			// Reset to the pin's idle level, so no false edge follows reset
			s1_q <= init;
			s2_q <= init;
			s3_q <= init;
			dout_q <= init;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				dout_q <= s3_q;
		end
	end
	assign rise = (s2_q == s3_q) && s3_q && !dout_q;
	assign fall = (s2_q == s3_q) && !s3_q && dout_q;
endmodule
`default_nettype wire
